// >>> logic/btcd_pkg.sv
package btcd_pkg;
    // Widths and counts
    localparam int NUM_SRC = 4;
    localparam int SRC_W = 2;
    // Immediate adaption
    localparam logic [15:0] BYTE_MASK = 16'h00ff;
    // Target construction
    localparam logic [15:0] VEC_SEGMENT = 16'h0000;
    localparam logic [6:0] VEC_MAX = 7'h7f;
    localparam logic [7:0] REL_SELF_ONE_WORD = 8'hff;
    localparam logic [7:0] REL_SELF_TWO_WORD = 8'hfe;
    localparam logic [15:0] REL_ONE_WORD_LEN = 16'h0002;
    // Four-bit condition codes
    localparam logic [3:0] COND_ALWAYS = 4'h0;
    localparam logic [3:0] COND_NOT_EQUAL_NOT_TABLE_END = 4'h1;
    localparam logic [3:0] COND_ZERO = 4'h2;
    localparam logic [3:0] COND_NOT_ZERO = 4'h3;
    localparam logic [3:0] COND_OVERFLOW = 4'h4;
    localparam logic [3:0] COND_NO_OVERFLOW = 4'h5;
    localparam logic [3:0] COND_NEGATIVE = 4'h6;
    localparam logic [3:0] COND_NOT_NEGATIVE = 4'h7;
    localparam logic [3:0] COND_CARRY = 4'h8;
    localparam logic [3:0] COND_NO_CARRY = 4'h9;
    localparam logic [3:0] COND_SIGNED_ABOVE = 4'ha;
    localparam logic [3:0] COND_SIGNED_BELOW_OR_EQUAL = 4'hb;
    localparam logic [3:0] COND_SIGNED_BELOW = 4'hc;
    localparam logic [3:0] COND_SIGNED_NOT_BELOW = 4'hd;
    localparam logic [3:0] COND_UNSIGNED_ABOVE = 4'he;
    localparam logic [3:0] COND_UNSIGNED_BELOW_OR_EQUAL = 4'hf;

    typedef enum logic [2:0] {
        BTCD_ABS = 3'h0,
        BTCD_REL = 3'h1,
        BTCD_IND = 3'h2,
        BTCD_SEG = 3'h3,
        BTCD_VEC = 3'h4
    } btcd_mode_t;

    typedef enum logic [2:0] {
        IMM_THREE = 3'h0,
        IMM_FOUR = 3'h1,
        IMM_BYTE = 3'h2,
        IMM_WIDE = 3'h3,
        IMM_MASK = 3'h4
    } btcd_imm_kind_t;

    // Gray path: idle, push ip, push psw, push csp; register read off idle
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH_IP = 3'b001,
        ST_PUSH_PSW = 3'b011,
        ST_PUSH_CSP = 3'b010,
        ST_READ_REG = 3'b100
    } btcd_state_t;

    typedef struct packed {
        logic e;
        logic z;
        logic v;
        logic c;
        logic n;
    } btcd_flags_t;

    typedef struct packed {
        logic valid;
        btcd_mode_t mode;
        logic [3:0] cond;
        logic [15:0] operand;
        logic [7:0] relOffset;
        logic [3:0] regIndex;
        logic [15:0] nextIp;
        logic [15:0] contextPointer;
    } btcd_branch_req_t;

    typedef struct packed {
        logic valid;
        btcd_imm_kind_t kind;
        logic byteOp;
        logic [15:0] raw;
    } btcd_imm_req_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic trap;
        logic ipLoad;
        logic [15:0] ip;
        logic cspLoad;
        logic [15:0] code_segment_pointer;
    } btcd_result_t;

    typedef struct packed {
        logic push;
        logic [15:0] data;
    } btcd_stack_t;
endpackage

// >>> logic/btcd_decode.sv
// What this block does
// - Short immediates and masks are zero-extended to the operation width.
// - A wide immediate keeps only its low byte in byte operations.
// - Branch modes other than segment and vector touch only the pointer; segment loads only from an absolute value.
// - Absolute target loads the pointer; an odd target raises a trap.
// - Relative target is next address plus twice the signed offset.
// - Offset FFh or FEh lands on the branch itself.
// - Indirect target is the word register at context pointer plus twice index.
// - An odd indirect target raises a trap instead of branching.
// - Segment operand loads the segment pointer from its two low bits.
// - Vector number sets segment zero and pointer to four times the number.
// - A conditional branch is taken only when its condition holds; code 0 always.
// - Codes 2h to 9h test zero, overflow, negative and carry set or clear.
// - Fh is zero or carry; Eh is its inverse.
// - Ch/Dh test negative xor overflow; Bh/Ah add zero to that.
// - Code 1h holds only when zero and end-of-table are both clear.
// - Interrupt entry pushes pointer, status word, and segment when segmented.
// - Pending requests are served by one of sixteen priority levels.
// - The indirect word register sits at context pointer plus twice the index.
module btcd_decode (
    input wire logic ref_clk,                                      // CPU clock
    input wire logic rst_b,                                        // Async reset, low
    input wire btcd_pkg::btcd_branch_req_t branchReq,              // Branch request
    output logic branchReady,                                      // Branch request taken
    output logic busy,                                             // Sequence in progress
    input wire btcd_pkg::btcd_imm_req_t immReq,                    // Immediate to adapt
    output logic immValid,                                         // Adapted value valid
    output logic [15:0] immResult,                                 // Adapted immediate
    input wire btcd_pkg::btcd_flags_t pswFlags,                    // Written-back flags
    input wire logic fwdValid,                                     // Forwarded flags valid
    input wire btcd_pkg::btcd_flags_t fwdFlags,                    // Flags of newest op
    output logic regRead,                                          // Register read strobe
    output logic [15:0] regAddr,                                   // Word register address
    input wire logic [15:0] regData,                               // Register contents
    input wire logic [btcd_pkg::NUM_SRC-1:0] intReq,               // Pending requests
    input wire logic [btcd_pkg::NUM_SRC-1:0][3:0] intLevel,        // Request levels
    input wire logic [btcd_pkg::NUM_SRC-1:0][6:0] intVector,       // Request vectors
    input wire logic [3:0] cpuLevel,                               // Current CPU level
    input wire logic segmented,                                    // Segmented mode
    input wire logic [15:0] instructionPointer,                    // Pointer to save
    input wire logic [15:0] programStatusWord,                     // Status word to save
    input wire logic [15:0] codeSegmentPointer,                    // Segment to save
    output logic [btcd_pkg::NUM_SRC-1:0] intAck,                   // Request accepted
    output btcd_pkg::btcd_stack_t stackOut,                        // System stack push
    output btcd_pkg::btcd_result_t result                          // Branch outcome
);
    import btcd_pkg::*;

    typedef struct packed {
        btcd_state_t state;
        btcd_result_t res;
        btcd_stack_t stack;
        logic regRead;
        logic [15:0] regAddr;
        logic immValid;
        logic [15:0] imm;
        logic [NUM_SRC-1:0] intAck;
        logic [6:0] vector;
        logic [15:0] savedPsw;
        logic [15:0] savedCsp;
    } btcd_regs_t;

    btcd_regs_t s_reg;
    btcd_regs_t s_next;
    btcd_flags_t effFlags;
    logic condOk;
    logic [SRC_W-1:0] srcSel;
    logic intFire;
    logic branchAccept;
    logic [15:0] relTarget;
    logic [15:0] indAddr;

    // Width adaption of immediate constants
    function automatic logic [15:0] adaptImm(input btcd_imm_kind_t kind, input logic byteOp,
                                             input logic [15:0] raw);
        logic [15:0] v;
        v = 16'h0000;
        case (kind)
            IMM_THREE: v = {13'h0000, raw[2:0]};
            IMM_FOUR: v = {12'h000, raw[3:0]};
            IMM_BYTE, IMM_MASK: v = {8'h00, raw[7:0]};
            IMM_WIDE: v = byteOp ? (raw & BYTE_MASK) : raw;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Condition code test against a flag set
    function automatic logic condTrue(input logic [3:0] cc, input btcd_flags_t f);
        logic t;
        logic sx;
        sx = f.n ^ f.v;
        t = 1'b0;
        case (cc)
            COND_ALWAYS: t = 1'b1;
            COND_NOT_EQUAL_NOT_TABLE_END: t = ~(f.z | f.e);
            COND_ZERO: t = f.z;
            COND_NOT_ZERO: t = ~f.z;
            COND_OVERFLOW: t = f.v;
            COND_NO_OVERFLOW: t = ~f.v;
            COND_NEGATIVE: t = f.n;
            COND_NOT_NEGATIVE: t = ~f.n;
            COND_CARRY: t = f.c;
            COND_NO_CARRY: t = ~f.c;
            COND_SIGNED_ABOVE: t = ~(f.z | sx);
            COND_SIGNED_BELOW_OR_EQUAL: t = f.z | sx;
            COND_SIGNED_BELOW: t = sx;
            COND_SIGNED_NOT_BELOW: t = ~sx;
            COND_UNSIGNED_ABOVE: t = ~(f.z | f.c);
            COND_UNSIGNED_BELOW_OR_EQUAL: t = f.z | f.c;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Highest pending level wins; equal levels go to the lowest index
    function automatic logic [SRC_W-1:0] pickSource(input logic [NUM_SRC-1:0] req,
                                                    input logic [NUM_SRC-1:0][3:0] lvl);
        logic [SRC_W-1:0] best;
        logic found;
        best = '0;
        found = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && (!found || lvl[i] > lvl[best])) begin
                best = SRC_W'(i);
                found = 1'b1;
            end
        end
        return best;
    endfunction

    // Flag forwarding and request arbitration
    always_comb begin
        effFlags = fwdValid ? fwdFlags : pswFlags;
        condOk = condTrue(branchReq.cond, effFlags);
        srcSel = pickSource(intReq, intLevel);
        intFire = (s_reg.state == ST_IDLE) && intReq[srcSel]
                  && (intLevel[srcSel] > cpuLevel);
        branchAccept = (s_reg.state == ST_IDLE) && !intFire && branchReq.valid;
        relTarget = branchReq.nextIp
                    + {{7{branchReq.relOffset[7]}}, branchReq.relOffset, 1'b0};
        indAddr = branchReq.contextPointer + {11'h000, branchReq.regIndex, 1'b0};
    end

    // Next-state logic for all held state
    always_comb begin
        s_next = s_reg;
        s_next.res = '0;
        s_next.stack = '0;
        s_next.regRead = 1'b0;
        s_next.intAck = '0;
        s_next.immValid = immReq.valid;
        if (immReq.valid) begin
            s_next.imm = adaptImm(immReq.kind, immReq.byteOp, immReq.raw);
        end
        case (s_reg.state)
            ST_IDLE: begin
                if (intFire) begin
                    s_next.intAck = NUM_SRC'(1) << srcSel;
                    s_next.vector = intVector[srcSel];
                    s_next.savedPsw = programStatusWord;
                    s_next.savedCsp = codeSegmentPointer;
                    s_next.stack.push = 1'b1;
                    s_next.stack.data = instructionPointer;
                    s_next.state = ST_PUSH_IP;
                end else if (branchAccept) begin
                    s_next.res.valid = 1'b1;
                    if (!condOk) begin
                        s_next.res.taken = 1'b0;
                    end else begin
                        case (branchReq.mode)
                            BTCD_ABS: begin
                                s_next.res.trap = branchReq.operand[0];
                                s_next.res.taken = !branchReq.operand[0];
                                s_next.res.ipLoad = !branchReq.operand[0];
                                s_next.res.ip = branchReq.operand;
                            end
                            BTCD_REL: begin
                                s_next.res.taken = 1'b1;
                                s_next.res.ipLoad = 1'b1;
                                s_next.res.ip = relTarget;
                            end
                            BTCD_IND: begin
                                s_next.res.valid = 1'b0;
                                s_next.regRead = 1'b1;
                                s_next.regAddr = indAddr;
                                s_next.state = ST_READ_REG;
                            end
                            BTCD_SEG: begin
                                s_next.res.taken = 1'b1;
                                s_next.res.cspLoad = 1'b1;
                                s_next.res.code_segment_pointer = {14'h0000, branchReq.operand[1:0]};
                            end
                            BTCD_VEC: begin
                                s_next.res.taken = 1'b1;
                                s_next.res.ipLoad = 1'b1;
                                s_next.res.ip = {7'h00, branchReq.operand[6:0] & VEC_MAX,
                                                 2'b00};
                                s_next.res.cspLoad = 1'b1;
                                s_next.res.code_segment_pointer = VEC_SEGMENT;
                            end
                            default: begin
                                s_next.res.taken = 1'b0;
                            end
                        endcase
                    end
                end
            end
            ST_READ_REG: begin
                s_next.res.valid = 1'b1;
                s_next.res.trap = regData[0];
                s_next.res.taken = !regData[0];
                s_next.res.ipLoad = !regData[0];
                s_next.res.ip = regData;
                s_next.state = ST_IDLE;
            end
            ST_PUSH_IP: begin
                s_next.stack.push = 1'b1;
                s_next.stack.data = s_reg.savedPsw;
                s_next.state = ST_PUSH_PSW;
            end
            ST_PUSH_PSW, ST_PUSH_CSP: begin
                if (s_reg.state == ST_PUSH_PSW && segmented) begin
                    s_next.stack.push = 1'b1;
                    s_next.stack.data = s_reg.savedCsp;
                    s_next.state = ST_PUSH_CSP;
                end else begin
                    s_next.res.valid = 1'b1;
                    s_next.res.taken = 1'b1;
                    s_next.res.ipLoad = 1'b1;
                    s_next.res.ip = {7'h00, s_reg.vector, 2'b00};
                    s_next.res.cspLoad = 1'b1;
                    s_next.res.code_segment_pointer = VEC_SEGMENT;
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign branchReady = (s_reg.state == ST_IDLE) && !intFire;
    assign busy = (s_reg.state != ST_IDLE);
    assign immValid = s_reg.immValid;
    assign immResult = s_reg.imm;
    assign regRead = s_reg.regRead;
    assign regAddr = s_reg.regAddr;
    assign intAck = s_reg.intAck;
    assign stackOut = s_reg.stack;
    assign result = s_reg.res;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence reqMode(btcd_mode_t m);
        branchAccept && condOk && branchReq.mode == m;
    endsequence

    sequence indRead;
        regRead && regAddr == $past(indAddr);
    endsequence

    sequence pushIpPsw;
        stackOut.push && stackOut.data == $past(instructionPointer)
        ##1 stackOut.push && stackOut.data == $past(programStatusWord, 2);
    endsequence

    chk_imm_short_ext: assert property (immReq.valid && immReq.kind == IMM_THREE
        |=> immValid && immResult == {13'h0000, $past(immReq.raw[2:0])})
        else $error("three-bit immediate not zero-extended");
    chk_wide_byte_cut: assert property (immReq.valid && immReq.kind == IMM_WIDE
        && immReq.byteOp |=> immResult[15:8] == 8'h00 && immResult[7:0] == $past(immReq.raw[7:0]))
        else $error("wide immediate not truncated in byte operation");
    chk_abs_odd_trap: assert property (reqMode(BTCD_ABS) && branchReq.operand[0]
        |=> result.valid && result.trap && !result.ipLoad && !result.cspLoad)
        else $error("odd absolute target did not trap");
    chk_rel_self: assert property (reqMode(BTCD_REL)
        && branchReq.relOffset == REL_SELF_ONE_WORD
        |=> result.ipLoad && result.ip == $past(branchReq.nextIp) - REL_ONE_WORD_LEN)
        else $error("relative FFh does not return to the branch");
    chk_ind_fetch: assert property (reqMode(BTCD_IND) |=> indRead ##1 result.valid
        && result.ip == $past(regData) && !result.cspLoad)
        else $error("indirect branch sequence wrong");
    chk_ind_odd_trap: assert property (regRead && regData[0]
        |=> result.trap && !result.ipLoad)
        else $error("odd indirect target did not trap");
    chk_seg_low_bits: assert property (reqMode(BTCD_SEG)
        |=> result.cspLoad && !result.ipLoad && result.code_segment_pointer == {14'h0000, $past(branchReq.operand[1:0])})
        else $error("segment load wrong");
    chk_vec_target: assert property (reqMode(BTCD_VEC)
        |=> result.code_segment_pointer == VEC_SEGMENT && result.ip == {7'h00, $past(branchReq.operand[6:0]), 2'b00})
        else $error("vector target wrong");
    chk_cond_false: assert property (branchAccept && !condOk
        |=> result.valid && !result.taken && !result.ipLoad && !result.cspLoad)
        else $error("false condition branched");
    chk_cc_unsigned_le: assert property (branchAccept
        && branchReq.cond == COND_UNSIGNED_BELOW_OR_EQUAL && !effFlags.z && !effFlags.c
        |=> result.valid && !result.taken)
        else $error("unsigned below-or-equal taken with zero and carry clear");
    chk_cc_table_end: assert property (branchAccept
        && branchReq.cond == COND_NOT_EQUAL_NOT_TABLE_END && effFlags.e |=> !result.taken)
        else $error("end-of-table condition taken");
    chk_flag_forward: assert property (branchAccept && fwdValid
        && branchReq.cond == COND_ZERO && branchReq.mode == BTCD_REL
        |=> result.taken == $past(fwdFlags.z))
        else $error("forwarded zero flag ignored");
    chk_int_push_order: assert property (intFire |=> pushIpPsw ##1
        (stackOut.push == $past(segmented)) ##[0:1] result.valid && result.code_segment_pointer == VEC_SEGMENT)
        else $error("interrupt entry push order wrong");
    chk_int_level: assert property (|intAck |-> $past(intLevel[srcSel]) > $past(cpuLevel))
        else $error("interrupt accepted at or below CPU level");
endmodule

// >>> bench/btcd_reg_model.sv
// Register file of the pipeline, answering register read strobes
module btcd_reg_model (
    input wire logic ref_clk,           // CPU clock
    input wire logic regRead,           // Read strobe
    input wire logic [15:0] regAddr,    // Word register address
    output logic [15:0] regData         // Register contents
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [15:0]];
    logic [15:0] last = 16'h0000;
    // Only a stored word at the exact address answers; otherwise a toggling pattern
    always @* begin
        if (regRead && mem.exists(regAddr)) begin
            regData = mem[regAddr];
        end else begin
            regData = ~last;
        end
    end
    // Remember the last value so idle cycles never repeat it
    always @(posedge ref_clk) begin
        last <= regData;
    end
endmodule

// >>> bench/btcd_decode_tb_top.sv
module btcd_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import btcd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b, branchReady, busy, immValid, fwdValid, regRead, segmented;
    btcd_branch_req_t branchReq;
    btcd_imm_req_t immReq;
    btcd_flags_t pswFlags, fwdFlags;
    logic [15:0] immResult, regAddr, regData, instructionPointer, programStatusWord;
    logic [15:0] codeSegmentPointer;
    logic [NUM_SRC-1:0] intReq, intAck;
    logic [NUM_SRC-1:0][3:0] intLevel;
    logic [NUM_SRC-1:0][6:0] intVector;
    logic [3:0] cpuLevel;
    btcd_stack_t stackOut;
    btcd_result_t result, e;
    int mismatches = 0;
    int check_count = 0;
    logic [15:0] immQ [$];
    logic [15:0] stkQ [$];
    logic [3:0] ackQ [$];
    btcd_result_t resQ [$];

    btcd_decode i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .branchReq(branchReq),
        .branchReady(branchReady), .busy(busy), .immReq(immReq), .immValid(immValid),
        .immResult(immResult), .pswFlags(pswFlags), .fwdValid(fwdValid), .fwdFlags(fwdFlags),
        .regRead(regRead), .regAddr(regAddr), .regData(regData), .intReq(intReq),
        .intLevel(intLevel), .intVector(intVector), .cpuLevel(cpuLevel), .segmented(segmented),
        .instructionPointer(instructionPointer), .programStatusWord(programStatusWord),
        .codeSegmentPointer(codeSegmentPointer), .intAck(intAck), .stackOut(stackOut),
        .result(result));
    btcd_reg_model i_part (.ref_clk(ref_clk), .regRead(regRead), .regAddr(regAddr),
        .regData(regData));

    // Clock
    initial forever #20 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
        check_count++;
        if (ex !== sn) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Truth table of the sixteen codes, code f at the top
    function automatic logic cnd(input logic [3:0] c, input btcd_flags_t f);
        logic x;
        logic [15:0] t;
        x = f.n ^ f.v;
        t = {f.z | f.c, ~(f.z | f.c), ~x, x, f.z | x, ~(f.z | x), ~f.c, f.c, ~f.n, f.n,
            ~f.v, f.v, ~f.z, f.z, ~(f.z | f.e), 1'b1};
        return t[c];
    endfunction

    // Issue one branch, note its outcome, hold it until accepted
    task automatic branch(input btcd_mode_t m, input logic [3:0] c, input logic [15:0] op,
        input logic [7:0] rel);
        btcd_result_t r;
        logic ok;
        logic [15:0] ra;
        int n;
        branchReq = {1'b1, m, c, op, rel, 4'($urandom), 16'($urandom), 16'($urandom)};
        pswFlags = 5'($urandom);
        fwdFlags = 5'($urandom);
        fwdValid = 1'($urandom);
        ra = branchReq.contextPointer + {branchReq.regIndex, 1'b0};
        i_part.mem[ra] = 16'($urandom);
        r = '0;
        r.valid = 1'b1;
        if (cnd(c, fwdValid ? fwdFlags : pswFlags)) begin
            case (m)
                BTCD_ABS: r.ip = op;
                BTCD_REL: r.ip = branchReq.nextIp + {{7{rel[7]}}, rel, 1'b0};
                BTCD_IND: r.ip = i_part.mem[ra];
                BTCD_SEG: r.code_segment_pointer = {14'h0, op[1:0]};
                default: begin
                    r.ip = {7'h0, op[6:0], 2'b00};
                    r.code_segment_pointer = VEC_SEGMENT;
                end
            endcase
            r.cspLoad = m inside {BTCD_SEG, BTCD_VEC};
            r.trap = m inside {BTCD_ABS, BTCD_IND} && r.ip[0];
            r.ipLoad = m != BTCD_SEG && !r.trap;
            r.taken = !r.trap;
        end
        resQ.push_back(r);
        n = 0;
        do begin
            @(negedge ref_clk);
            ok = branchReady;
            @(posedge ref_clk);
            n++;
        end while (ok !== 1'b1 && n < 20);
        // Request stays up; the next call or the caller replaces it one step later
        #1;
    endtask

    // One interrupt entry with a known winner above the CPU level
    task automatic irq();
        int w;
        logic [3:0] best;
        intLevel = 16'($urandom);
        intVector = 28'($urandom);
        segmented = 1'($urandom);
        cpuLevel = 4'($urandom % 15);
        w = $urandom % 4;
        intLevel[w] = 4'hf;
        intReq = 4'($urandom) | (4'h1 << w);
        {instructionPointer, programStatusWord, codeSegmentPointer} = 48'({$urandom, $urandom});
        best = cpuLevel;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (intReq[i] && intLevel[i] > best) begin
                best = intLevel[i];
                w = i;
            end
        end
        ackQ.push_back(4'h1 << w);
        stkQ.push_back(instructionPointer);
        stkQ.push_back(programStatusWord);
        if (segmented) stkQ.push_back(codeSegmentPointer);
        resQ.push_back({1'b1, 1'b1, 1'b0, 1'b1, {7'h0, intVector[w], 2'b00}, 1'b1, 16'h0});
        for (int n = 0; n < 20 && intAck === 4'h0; n++) @(posedge ref_clk) #1;
        chk("busy", 16'h0001, {15'h0000, busy});
        intReq = '0;
        repeat (6) @(posedge ref_clk) #1;
        chk("idle", 16'h0000, {15'h0000, busy});
    endtask

    // Watch outputs and compare with the oldest note
    always begin
        @(posedge ref_clk);
        #2;
        if (immValid === 1'b1) chk("immResult", immQ.pop_front(), immResult);
        if (stackOut.push === 1'b1) chk("stack", stkQ.pop_front(), stackOut.data);
        if (intAck !== 4'h0) chk("intAck", ackQ.pop_front(), intAck);
        if (result.valid === 1'b1) begin
            e = resQ.pop_front();
            chk("flags", {e.taken, e.trap, e.ipLoad, e.cspLoad},
                {result.taken, result.trap, result.ipLoad, result.cspLoad});
            if (e.ipLoad) chk("ip", e.ip, result.ip);
            if (e.cspLoad) chk("csp", e.code_segment_pointer, result.code_segment_pointer);
        end
    end

    // Watchdog
    initial begin
        #(40 * 3000);
        mismatches++;
        conclude();
    end

    // Main sequence
    initial begin
        void'($urandom(34140));
        {rst_b, branchReq, immReq, pswFlags, fwdFlags, fwdValid, segmented} = '0;
        {intReq, intLevel, intVector, cpuLevel} = '0;
        {instructionPointer, programStatusWord, codeSegmentPointer} = '0;
        repeat (5) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        for (int k = 0; k < 40; k++) begin
            immReq.valid = 1'b1;
            immReq.kind = btcd_imm_kind_t'(k % 5);
            immReq.byteOp = 1'((k / 5) % 2);
            immReq.raw = 16'($urandom) & (k % 5 == 0 ? 16'h0007 : k % 5 == 1 ? 16'h000f :
                k % 5 == 3 ? 16'hffff : BYTE_MASK);
            immQ.push_back(immReq.kind == IMM_WIDE && immReq.byteOp ?
                immReq.raw & BYTE_MASK : immReq.raw);
            @(posedge ref_clk) #1;
        end
        immReq.valid = 1'b0;
        $display("test immediate done");
        for (int k = 0; k < 80; k++) begin
            branch(btcd_mode_t'(k % 5), 4'(k % 16), k % 5 == 4 ? 16'($urandom % 128) :
                16'($urandom), k % 4 == 0 ? REL_SELF_ONE_WORD : 8'($urandom));
        end
        branchReq.valid = 1'b0;
        repeat (4) @(posedge ref_clk) #1;
        $display("test branch done");
        repeat (6) irq();
        $display("test interrupt done");
        conclude();
    end
endmodule
